/* shared/cml_pkg.sv */
// Purpose: shared types and constants for the coherent line state block
// Assumes: one clock, synchronous active-high reset
// Notes:   line storage is a small direct-indexed array of flip-flops
package cml_pkg;

  localparam int unsigned NUM_LINES = 4;
  localparam int unsigned IDX_W     = 2;
  localparam int unsigned DATA_W    = 32;

  // upper read response field: shared flag and dirty-pass flag
  localparam int unsigned RESP_SHARED_BIT = 3;
  localparam int unsigned RESP_DIRTY_BIT  = 2;
  localparam logic [1:0]  RESP_UNIQUE     = 2'h0;

  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

  typedef enum logic [2:0]
  {
    LS_I,
    LS_UC,
    LS_UD,
    LS_SC,
    LS_SD
  } cml_line_t;

  localparam cml_line_t LINE_RST = LS_I;

  typedef enum logic [2:0]
  {
    OP_MAKE_UNIQUE,
    OP_MAKE_INVALID,
    OP_WRITE_NO_SNOOP,
    OP_WRITE_UNIQUE,
    OP_WRITE_LINE_UNIQUE
  } cml_op_t;

  typedef enum
  {
    ST_IDLE,
    ST_DECIDE,
    ST_PREP,
    ST_ISSUE,
    ST_WAIT,
    ST_UPD
  } cml_fsm_t;

endpackage

/* design/cml_line_array.sv */
// Purpose: per-line state and data storage, one write and two read ports
// Assumes: write and read use the same clock; reads are combinational
// Notes:   a write is seen on the read ports from the next cycle
`timescale 1ns/1ps
module cml_line_array
(
  input  wire logic                         clock,
  input  wire logic                         sys_rst,
  input  wire logic                         wr_en,
  input  wire logic                         wr_data_en,
  input  wire logic [cml_pkg::IDX_W-1:0]    wr_index,
  input  wire cml_pkg::cml_line_t           wr_state,
  input  wire logic [cml_pkg::DATA_W-1:0]   wr_data,
  input  wire logic [cml_pkg::IDX_W-1:0]    rd_index,
  output cml_pkg::cml_line_t                rd_state,
  output logic      [cml_pkg::DATA_W-1:0]   rd_data,
  input  wire logic [cml_pkg::IDX_W-1:0]    lk_index,
  output cml_pkg::cml_line_t                lk_state,
  output logic      [cml_pkg::DATA_W-1:0]   lk_data
);

  cml_pkg::cml_line_t          line_state [cml_pkg::NUM_LINES];
  logic [cml_pkg::DATA_W-1:0]  line_data  [cml_pkg::NUM_LINES];

  genvar g;
  generate
    for (g = 0; g < cml_pkg::NUM_LINES; g++)
    begin : g_line
      always_ff @(posedge clock)
      begin
        if (sys_rst)
        begin
          line_state[g] <= cml_pkg::LINE_RST;
          line_data[g]  <= cml_pkg::DATA_RST;
        end
        else if (wr_en && (int'(wr_index) == g))
        begin
          line_state[g] <= wr_state;
          if (wr_data_en)
          begin
            line_data[g] <= wr_data;
          end
        end
      end
    end
  endgenerate

  assign rd_state = line_state[rd_index];
  assign rd_data  = line_data[rd_index];
  assign lk_state = line_state[lk_index];
  assign lk_data  = line_data[lk_index];

endmodule

/* design/cml_legal_check.sv */
// Purpose: legal end-state table for make and write transactions
// Assumes: start and end states are the requester's own line
// Notes:   purely combinational; result is registered by the caller
`timescale 1ns/1ps
module cml_legal_check
(
  input  wire cml_pkg::cml_op_t    op,
  input  wire cml_pkg::cml_line_t  start_state,
  input  wire cml_pkg::cml_line_t  end_state,
  input  wire logic                full_line,
  input  wire logic                snoop_filter,
  output logic                     legal
);

  always_comb
  begin
    legal = 1'b0;
    case (op)
      cml_pkg::OP_MAKE_UNIQUE:
        legal = (end_state == cml_pkg::LS_UD) ||
                (end_state == cml_pkg::LS_SD);
      cml_pkg::OP_MAKE_INVALID:
        legal = (start_state == cml_pkg::LS_I) &&
                (end_state == cml_pkg::LS_I);
      cml_pkg::OP_WRITE_NO_SNOOP:
        legal = (end_state == cml_pkg::LS_I) ||
                (end_state == cml_pkg::LS_UC) ||
                (end_state == cml_pkg::LS_SC);
      cml_pkg::OP_WRITE_UNIQUE,
      cml_pkg::OP_WRITE_LINE_UNIQUE:
      begin
        if (start_state == cml_pkg::LS_I)
        begin
          legal = (end_state == cml_pkg::LS_I);
        end
        else if ((start_state == cml_pkg::LS_UC) ||
                 (start_state == cml_pkg::LS_SC))
        begin
          legal = (end_state == cml_pkg::LS_SC) ||
                  (!snoop_filter && (end_state == cml_pkg::LS_I));
        end
        else
        begin
          legal = 1'b0;
        end
      end
      default:
        legal = 1'b0;
    endcase
    if ((start_state == cml_pkg::LS_I) && (end_state != cml_pkg::LS_I) &&
        !full_line)
    begin
      legal = 1'b0;
    end
  end

endmodule

/* design/cml_master.sv */
// Purpose: coherent caching master, make and write line state tracking
// Assumes: one request at a time; interconnect keeps its own duties
// Notes:   refused requests leave the line untouched
//
// Summary of operation
// - make unique only with full-line store
// - make unique returns no data
// - make unique from I/SC/SD ends UD
// - make unique from UC/UD ends UD
// - invalidate own copy before make invalid
// - make invalid response zero, line stays I
// - write kinds go on write address channel
// - no-snoop write only for private regions
// - no-snoop write: I, UC kept; UD to UC
// - no-snoop write from SC/SD ends UC
// - I becomes valid only after full store
// - unique write: I stays, clean goes SC
// - clean copy refreshed on unique write answer
// - line unique write covers whole line
// - line unique write states match unique write
// - clean copy refreshed on line write answer
// - make kinds go on read address channel
// - no unique write while writebacks pending
`timescale 1ns/1ps
module cml_master
(
  input  wire logic                         clock,
  input  wire logic                         sys_rst,
  input  wire logic                         snoop_filter,
  input  wire logic                         req_valid,
  input  wire cml_pkg::cml_op_t             req_op,
  input  wire logic [cml_pkg::IDX_W-1:0]    req_index,
  input  wire logic                         req_full_line,
  input  wire logic                         req_shareable,
  input  wire logic [cml_pkg::DATA_W-1:0]   req_data,
  input  wire logic                         wb_pending,
  output logic                              req_ready,
  output logic                              done,
  output logic                              refused,
  output logic                              proto_err,
  input  wire logic [cml_pkg::IDX_W-1:0]    lk_index,
  output cml_pkg::cml_line_t                lk_state,
  output logic      [cml_pkg::DATA_W-1:0]   lk_data,
  output logic                              ar_valid,
  output cml_pkg::cml_op_t                  ar_op,
  output logic      [cml_pkg::IDX_W-1:0]    ar_index,
  input  wire logic                         ar_ready,
  input  wire logic                         r_valid,
  input  wire logic [3:0]                   r_resp,
  output logic                              aw_valid,
  output cml_pkg::cml_op_t                  aw_op,
  output logic      [cml_pkg::IDX_W-1:0]    aw_index,
  output logic      [cml_pkg::DATA_W-1:0]   aw_data,
  input  wire logic                         aw_ready,
  input  wire logic                         b_valid
);

  cml_pkg::cml_fsm_t           st;
  cml_pkg::cml_fsm_t           next_st;
  cml_pkg::cml_op_t            cur_op;
  cml_pkg::cml_line_t          cur_start;
  logic [cml_pkg::IDX_W-1:0]   cur_index;
  logic [cml_pkg::DATA_W-1:0]  cur_data;
  logic                        cur_full;
  logic                        cur_share;
  logic [1:0]                  cur_resp;
  cml_pkg::cml_line_t          rd_state;
  logic [cml_pkg::DATA_W-1:0]  rd_data;
  cml_pkg::cml_line_t          lk_rd_state;
  logic [cml_pkg::DATA_W-1:0]  lk_rd_data;
  cml_pkg::cml_line_t          next_line;
  logic                        cur_make;
  logic                        cur_uniq;
  logic                        refuse;
  logic                        chk_legal;
  logic                        wr_en;
  logic                        wr_data_en;
  cml_pkg::cml_line_t          wr_state;

  assign cur_make = (cur_op == cml_pkg::OP_MAKE_UNIQUE) ||
                    (cur_op == cml_pkg::OP_MAKE_INVALID);
  assign cur_uniq = (cur_op == cml_pkg::OP_WRITE_UNIQUE) ||
                    (cur_op == cml_pkg::OP_WRITE_LINE_UNIQUE);

  // request screening against line state and region
  always_comb
  begin
    refuse = 1'b0;
    case (cur_op)
      cml_pkg::OP_MAKE_UNIQUE:
        refuse = !cur_full || !cur_share;
      cml_pkg::OP_WRITE_NO_SNOOP:
        refuse = cur_share;
      cml_pkg::OP_WRITE_LINE_UNIQUE:
        refuse = !cur_full || !cur_share ||
                 (rd_state == cml_pkg::LS_UD) ||
                 (rd_state == cml_pkg::LS_SD);
      cml_pkg::OP_WRITE_UNIQUE:
        refuse = !cur_share || (rd_state == cml_pkg::LS_UD) ||
                 (rd_state == cml_pkg::LS_SD);
      default:
        refuse = 1'b0;
    endcase
  end

  // expected end state of the requester's line
  always_comb
  begin
    next_line = cml_pkg::LS_I;
    case (cur_op)
      cml_pkg::OP_MAKE_UNIQUE:
        next_line = cml_pkg::LS_UD;
      cml_pkg::OP_MAKE_INVALID:
        next_line = cml_pkg::LS_I;
      cml_pkg::OP_WRITE_NO_SNOOP:
        next_line = (cur_start == cml_pkg::LS_I) ?
                    cml_pkg::LS_I : cml_pkg::LS_UC;
      cml_pkg::OP_WRITE_UNIQUE,
      cml_pkg::OP_WRITE_LINE_UNIQUE:
        next_line = (cur_start == cml_pkg::LS_I) ?
                    cml_pkg::LS_I : cml_pkg::LS_SC;
      default:
        next_line = cml_pkg::LS_I;
    endcase
  end

  always_comb
  begin
    next_st = st;
    case (st)
      cml_pkg::ST_IDLE:
        if (req_valid && req_ready)
        begin
          next_st = cml_pkg::ST_DECIDE;
        end
      cml_pkg::ST_DECIDE:
        if (refuse)
        begin
          next_st = cml_pkg::ST_IDLE;
        end
        else if ((cur_op == cml_pkg::OP_MAKE_INVALID) &&
                 (rd_state != cml_pkg::LS_I))
        begin
          next_st = cml_pkg::ST_PREP;
        end
        else
        begin
          next_st = cml_pkg::ST_ISSUE;
        end
      cml_pkg::ST_PREP:
        next_st = cml_pkg::ST_ISSUE;
      cml_pkg::ST_ISSUE:
        if ((ar_valid && ar_ready) || (aw_valid && aw_ready))
        begin
          next_st = cml_pkg::ST_WAIT;
        end
      cml_pkg::ST_WAIT:
        if (cur_make ? r_valid : b_valid)
        begin
          next_st = cml_pkg::ST_UPD;
        end
      cml_pkg::ST_UPD:
        next_st = cml_pkg::ST_IDLE;
      default:
        next_st = cml_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st        <= cml_pkg::ST_IDLE;
      req_ready <= 1'b0;
    end
    else
    begin
      st        <= next_st;
      req_ready <= (next_st == cml_pkg::ST_IDLE);
    end
  end

  // request capture and start state
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cur_op    <= cml_pkg::OP_MAKE_UNIQUE;
      cur_index <= '0;
      cur_data  <= cml_pkg::DATA_RST;
      cur_full  <= 1'b0;
      cur_share <= 1'b0;
      cur_start <= cml_pkg::LINE_RST;
      cur_resp  <= cml_pkg::RESP_UNIQUE;
    end
    else
    begin
      if (st == cml_pkg::ST_IDLE && req_valid && req_ready)
      begin
        cur_op    <= req_op;
        cur_index <= req_index;
        cur_data  <= req_data;
        cur_full  <= req_full_line;
        cur_share <= req_shareable;
      end
      if (st == cml_pkg::ST_DECIDE)
      begin
        cur_start <= rd_state;
      end
      else if (st == cml_pkg::ST_PREP)
      begin
        cur_start <= cml_pkg::LS_I;
      end
      if (st == cml_pkg::ST_WAIT && r_valid && cur_make)
      begin
        cur_resp <= {r_resp[cml_pkg::RESP_SHARED_BIT],
                     r_resp[cml_pkg::RESP_DIRTY_BIT]};
      end
    end
  end

  // read address channel carries only make kinds
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ar_valid <= 1'b0;
    end
    else if (ar_valid && ar_ready)
    begin
      ar_valid <= 1'b0;
    end
    else if (st == cml_pkg::ST_ISSUE && cur_make)
    begin
      ar_valid <= 1'b1;
    end
  end

  // write address channel, unique writes held back behind pending writebacks
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      aw_valid <= 1'b0;
    end
    else if (aw_valid && aw_ready)
    begin
      aw_valid <= 1'b0;
    end
    else if (st == cml_pkg::ST_ISSUE && !cur_make &&
             !(cur_uniq && wb_pending))
    begin
      aw_valid <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ar_op    <= cml_pkg::OP_MAKE_UNIQUE;
      ar_index <= '0;
      aw_op    <= cml_pkg::OP_WRITE_NO_SNOOP;
      aw_index <= '0;
      aw_data  <= cml_pkg::DATA_RST;
    end
    else
    begin
      ar_op    <= cur_op;
      ar_index <= cur_index;
      aw_op    <= cur_op;
      aw_index <= cur_index;
      aw_data  <= cur_data;
    end
  end

  // line update; store data lands with the answer, never read data
  assign wr_en      = (st == cml_pkg::ST_PREP) || (st == cml_pkg::ST_UPD);
  assign wr_state   = (st == cml_pkg::ST_PREP) ? cml_pkg::LS_I : next_line;
  assign wr_data_en = (st == cml_pkg::ST_UPD) &&
                      (next_line != cml_pkg::LS_I);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      done      <= 1'b0;
      refused   <= 1'b0;
      proto_err <= 1'b0;
      lk_state  <= cml_pkg::LINE_RST;
      lk_data   <= cml_pkg::DATA_RST;
    end
    else
    begin
      done      <= (st == cml_pkg::ST_UPD);
      refused   <= (st == cml_pkg::ST_DECIDE) && refuse;
      proto_err <= (st == cml_pkg::ST_UPD) &&
                   (!chk_legal || (cur_make &&
                   cur_resp != cml_pkg::RESP_UNIQUE));
      lk_state  <= lk_rd_state;
      lk_data   <= lk_rd_data;
    end
  end

  cml_line_array cml_line_array_inst
  (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .wr_en      (wr_en),
    .wr_data_en (wr_data_en),
    .wr_index   (cur_index),
    .wr_state   (wr_state),
    .wr_data    (cur_data),
    .rd_index   (cur_index),
    .rd_state   (rd_state),
    .rd_data    (rd_data),
    .lk_index   (lk_index),
    .lk_state   (lk_rd_state),
    .lk_data    (lk_rd_data)
  );

  cml_legal_check cml_legal_check_inst
  (
    .op           (cur_op),
    .start_state  (cur_start),
    .end_state    (next_line),
    .full_line    (cur_full),
    .snoop_filter (snoop_filter),
    .legal        (chk_legal)
  );

  sequence s_mu_upd;
    st == cml_pkg::ST_UPD && cur_op == cml_pkg::OP_MAKE_UNIQUE;
  endsequence

  sequence s_mi_upd;
    st == cml_pkg::ST_UPD && cur_op == cml_pkg::OP_MAKE_INVALID;
  endsequence

  property p_mu_full;
    @(posedge clock) disable iff (sys_rst)
    ar_valid && ar_op == cml_pkg::OP_MAKE_UNIQUE |-> cur_full && cur_share;
  endproperty
  a_mu_full: assert property (p_mu_full)
    else $error("make unique issued without full store");

  property p_mu_nodata;
    @(posedge clock) disable iff (sys_rst)
    s_mu_upd |=> rd_data == $past(cur_data);
  endproperty
  a_mu_nodata: assert property (p_mu_nodata)
    else $error("make unique line data not the store data");

  property p_mu_end;
    @(posedge clock) disable iff (sys_rst)
    s_mu_upd ##1 done |-> rd_state == cml_pkg::LS_UD;
  endproperty
  a_mu_end: assert property (p_mu_end)
    else $error("make unique did not end in UD");

  property p_mi_prior;
    @(posedge clock) disable iff (sys_rst)
    ar_valid && ar_op == cml_pkg::OP_MAKE_INVALID
      |-> rd_state == cml_pkg::LS_I;
  endproperty
  a_mi_prior: assert property (p_mi_prior)
    else $error("make invalid issued with valid own copy");

  property p_mi_end;
    @(posedge clock) disable iff (sys_rst)
    s_mi_upd |=> rd_state == cml_pkg::LS_I && done;
  endproperty
  a_mi_end: assert property (p_mi_end)
    else $error("make invalid left line valid");

  property p_wr_chan;
    @(posedge clock) disable iff (sys_rst)
    aw_valid |-> aw_op != cml_pkg::OP_MAKE_UNIQUE &&
                 aw_op != cml_pkg::OP_MAKE_INVALID && !ar_valid;
  endproperty
  a_wr_chan: assert property (p_wr_chan)
    else $error("make kind on write address channel");

  property p_rd_chan;
    @(posedge clock) disable iff (sys_rst)
    ar_valid |-> ar_op == cml_pkg::OP_MAKE_UNIQUE ||
                 ar_op == cml_pkg::OP_MAKE_INVALID;
  endproperty
  a_rd_chan: assert property (p_rd_chan)
    else $error("write kind on read address channel");

  property p_wns_priv;
    @(posedge clock) disable iff (sys_rst)
    aw_valid && aw_op == cml_pkg::OP_WRITE_NO_SNOOP |-> !cur_share;
  endproperty
  a_wns_priv: assert property (p_wns_priv)
    else $error("no-snoop write to shared region");

  property p_wu_wb;
    @(posedge clock) disable iff (sys_rst)
    $rose(aw_valid) && $past(wb_pending) |-> !cur_uniq;
  endproperty
  a_wu_wb: assert property (p_wu_wb)
    else $error("unique write issued with writebacks pending");

  property p_no_alloc;
    @(posedge clock) disable iff (sys_rst)
    st == cml_pkg::ST_UPD && cur_start == cml_pkg::LS_I && !cur_full
      |=> rd_state == cml_pkg::LS_I;
  endproperty
  a_no_alloc: assert property (p_no_alloc)
    else $error("line allocated without full store");

  property p_wu_data;
    @(posedge clock) disable iff (sys_rst)
    st == cml_pkg::ST_UPD && cur_uniq && cur_start != cml_pkg::LS_I
      |=> rd_state == cml_pkg::LS_SC && rd_data == $past(cur_data);
  endproperty
  a_wu_data: assert property (p_wu_data)
    else $error("clean copy not refreshed on write answer");

  property p_wlu_full;
    @(posedge clock) disable iff (sys_rst)
    aw_valid && aw_op == cml_pkg::OP_WRITE_LINE_UNIQUE |-> cur_full;
  endproperty
  a_wlu_full: assert property (p_wlu_full)
    else $error("line unique write not full line");

  property p_legal;
    @(posedge clock) disable iff (sys_rst)
    st == cml_pkg::ST_UPD && (!chk_legal || (cur_make &&
      cur_resp != cml_pkg::RESP_UNIQUE)) |=> proto_err && done;
  endproperty
  a_legal: assert property (p_legal)
    else $error("illegal transition not flagged");

endmodule

/* bench/cml_ic_model.sv */
// Purpose: interconnect stand-in facing the coherent master
// Assumes: one request outstanding at a time
// Notes:   slow delays ready and answer; bad sets the shared flag
`timescale 1ns/1ps
module cml_ic_model
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        slow,
  input  wire logic        bad,
  input  wire logic        ar_valid,
  input  wire logic        aw_valid,
  output logic             ar_ready,
  output logic             aw_ready,
  output logic             r_valid,
  output logic [3:0]       r_resp,
  output logic             b_valid
);
  logic [2:0] hold;
  logic [2:0] lag;
  logic       rd_pend;
  logic       wr_pend;
  logic [3:0] junk;

  assign ar_ready = ar_valid && (!slow || hold == 3'h3);
  assign aw_ready = aw_valid && (!slow || hold == 3'h3);
  // other copies dropped and write passed on before answering
  assign r_resp = r_valid ? {bad, 3'h0} : junk;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      hold <= 3'h0;
      lag <= 3'h0;
      rd_pend <= 1'b0;
      wr_pend <= 1'b0;
      junk <= 4'h5;
      r_valid <= 1'b0;
      b_valid <= 1'b0;
    end
    else
    begin
      junk <= ~junk;
      r_valid <= 1'b0;
      b_valid <= 1'b0;
      hold <= (ar_valid || aw_valid) ? hold + 3'h1 : 3'h0;
      if (ar_ready || aw_ready)
      begin
        hold <= 3'h0;
        rd_pend <= ar_ready;
        wr_pend <= aw_ready;
        lag <= slow ? 3'h4 : 3'h0;
      end
      else if ((rd_pend || wr_pend) && lag != 3'h0)
        lag <= lag - 3'h1;
      else if (rd_pend || wr_pend)
      begin
        r_valid <= rd_pend;
        b_valid <= wr_pend;
        rd_pend <= 1'b0;
        wr_pend <= 1'b0;
      end
    end
  end
endmodule

/* bench/cml_master_tb_top.sv */
// Purpose: self-checking bench for the coherent master
// Assumes: inputs driven at falling edge, outputs read there too
// Notes:   expected line states kept in a shadow table
`timescale 1ns/1ps
`define CMP(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  err_count++; $display("unexpected %s exp %0h seen %0h", n, e, g); end end
module cml_master_tb_top;
  typedef struct
  {
    logic               rf;
    logic               pe;
    cml_pkg::cml_line_t st;
    logic [31:0]        dt;
  } cml_note_t;
  logic               clock = 1'b0;
  logic               sys_rst = 1'b1;
  logic               snoop_filter, req_valid, req_full_line;
  logic               req_shareable, wb_pending, slow, bad;
  cml_pkg::cml_op_t   req_op, ar_op, aw_op;
  logic [1:0]         req_index, lk_index, ar_index, aw_index;
  logic [31:0]        req_data, lk_data, aw_data;
  logic               req_ready, done, refused, proto_err;
  logic               ar_valid, ar_ready, r_valid;
  logic               aw_valid, aw_ready, b_valid;
  logic [3:0]         r_resp;
  cml_pkg::cml_line_t lk_state;
  logic [15:0]        lfsr = 16'h0017;
  int                 err_count = 0;
  int                 num_checks = 0;
  int                 cyc = 0;
  cml_note_t          notes[$];
  cml_note_t          mn;
  cml_pkg::cml_line_t exp_st [4] = '{default: cml_pkg::LS_I};
  logic [31:0]        exp_dt [4] = '{default: 32'h0};
  localparam logic [4:0] SEQ [17] = '{5'h03, 5'h0A, 5'h0D, 5'h03, 5'h0D,
    5'h13, 5'h0A, 5'h03, 5'h0A, 5'h13, 5'h05, 5'h13, 5'h0A, 5'h01, 5'h02,
    5'h0B, 5'h11};

  always #50 clock = ~clock;

  cml_master cml_master_inst
  (
    .clock(clock), .sys_rst(sys_rst), .snoop_filter(snoop_filter),
    .req_valid(req_valid), .req_op(req_op), .req_index(req_index),
    .req_full_line(req_full_line), .req_shareable(req_shareable),
    .req_data(req_data), .wb_pending(wb_pending), .req_ready(req_ready),
    .done(done), .refused(refused), .proto_err(proto_err),
    .lk_index(lk_index), .lk_state(lk_state), .lk_data(lk_data),
    .ar_valid(ar_valid), .ar_op(ar_op), .ar_index(ar_index),
    .ar_ready(ar_ready), .r_valid(r_valid), .r_resp(r_resp),
    .aw_valid(aw_valid), .aw_op(aw_op), .aw_index(aw_index),
    .aw_data(aw_data), .aw_ready(aw_ready), .b_valid(b_valid)
  );

  cml_ic_model cml_ic_model_inst
  (
    .clock(clock), .sys_rst(sys_rst), .slow(slow), .bad(bad),
    .ar_valid(ar_valid), .aw_valid(aw_valid), .ar_ready(ar_ready),
    .aw_ready(aw_ready), .r_valid(r_valid), .r_resp(r_resp),
    .b_valid(b_valid)
  );

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task conclude;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic send(input cml_pkg::cml_op_t op, input logic [1:0] ix,
                      input logic fl, input logic sh);
    cml_note_t          n;
    cml_pkg::cml_line_t s;
    int                 k;
    lfsr = lfsr_next(lfsr);
    s = exp_st[ix];
    case (op)
      cml_pkg::OP_MAKE_UNIQUE:    n.rf = !fl || !sh;
      cml_pkg::OP_MAKE_INVALID:   n.rf = 1'b0;
      cml_pkg::OP_WRITE_NO_SNOOP: n.rf = sh;
      cml_pkg::OP_WRITE_UNIQUE:   n.rf = !sh || s == cml_pkg::LS_UD ||
                                         s == cml_pkg::LS_SD;
      default:                    n.rf = !fl || !sh || s == cml_pkg::LS_UD ||
                                         s == cml_pkg::LS_SD;
    endcase
    case (op)
      cml_pkg::OP_MAKE_UNIQUE:    n.st = cml_pkg::LS_UD;
      cml_pkg::OP_MAKE_INVALID:   n.st = cml_pkg::LS_I;
      cml_pkg::OP_WRITE_NO_SNOOP: n.st = s == cml_pkg::LS_I ? cml_pkg::LS_I :
                                         cml_pkg::LS_UC;
      default:                    n.st = s == cml_pkg::LS_I ? cml_pkg::LS_I :
                                         cml_pkg::LS_SC;
    endcase
    if (n.rf)
      n.st = s;
    else
    begin
      exp_st[ix] = n.st;
      if (n.st != cml_pkg::LS_I)
        exp_dt[ix] = {lfsr, ~lfsr};
    end
    n.dt = exp_dt[ix];
    n.pe = bad;
    notes.push_back(n);
    req_op = op;
    req_index = ix;
    lk_index = ix;
    req_full_line = fl;
    req_shareable = sh;
    req_data = {lfsr, ~lfsr};
    req_valid = 1'b1;
    for (k = 0; k < 100 && req_ready !== 1'b1; k++)
      @(negedge clock);
    @(negedge clock);
    req_valid = 1'b0;
  endtask

  task automatic fin;
    int k;
    for (k = 0; k < 300 && done !== 1'b1 && refused !== 1'b1; k++)
      @(negedge clock);
    `CMP("finish", 1'b1, done | refused)
    repeat (2) @(negedge clock);
  endtask

  always @(negedge clock)
  begin
    if (done === 1'b1 || refused === 1'b1)
    begin
      mn = notes.pop_front();
      `CMP("refused", mn.rf, refused)
      `CMP("done", !mn.rf, done)
      `CMP("proto_err", mn.pe, proto_err)
      @(negedge clock);
      `CMP("state", mn.st, lk_state)
      if (mn.st != cml_pkg::LS_I)
        `CMP("data", mn.dt, lk_data)
    end
  end

  always @(negedge clock)
  begin
    if (ar_valid === 1'b1)
    begin
      `CMP("ar_op", req_op, ar_op)
      `CMP("ar_grp", 1'b1, req_op <= cml_pkg::OP_MAKE_INVALID)
      `CMP("ar_index", req_index, ar_index)
    end
    if (aw_valid === 1'b1)
    begin
      `CMP("aw_op", req_op, aw_op)
      `CMP("aw_grp", 1'b1, req_op > cml_pkg::OP_MAKE_INVALID)
      `CMP("aw_index", req_index, aw_index)
      `CMP("aw_data", req_data, aw_data)
    end
  end

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      err_count++;
      conclude();
    end
  end

  initial
  begin
    {snoop_filter, req_valid, req_full_line, req_shareable} = 4'h0;
    {wb_pending, slow, bad} = 3'h0;
    req_op = cml_pkg::OP_MAKE_UNIQUE;
    req_index = 2'h0;
    lk_index = 2'h0;
    req_data = 32'h0;
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    `CMP("rst_state", cml_pkg::LS_I, lk_state)
    `CMP("rst_ready", 1'b1, req_ready)
    for (int i = 0; i < 17; i++)
    begin
      snoop_filter = i[0];
      send(cml_pkg::cml_op_t'(SEQ[i][4:2]), 2'h1, SEQ[i][1], SEQ[i][0]);
      fin();
    end
    wb_pending = 1'b1;
    send(cml_pkg::OP_WRITE_UNIQUE, 2'h2, 1'b1, 1'b1);
    repeat (8)
    begin
      `CMP("aw_hold", 1'b0, aw_valid)
      @(negedge clock);
    end
    wb_pending = 1'b0;
    fin();
    bad = 1'b1;
    send(cml_pkg::OP_MAKE_INVALID, 2'h3, 1'b0, 1'b1);
    fin();
    bad = 1'b0;
    repeat (80)
    begin
      slow = lfsr[0];
      snoop_filter = lfsr[1];
      send(cml_pkg::cml_op_t'(lfsr[4:2] % 3'h5), lfsr[6:5],
           lfsr[7] | lfsr[8], lfsr[9] | lfsr[10]);
      fin();
    end
    conclude();
  end
endmodule
